// ==== tsq_bus_model.sv ====
`timescale 1ns/1ns
// Bus of the system under test; idle lines toggle so stale data
// never passes for a sampled cycle
module tsq_bus_model (
  // Clock
  input wire logic clk,
  // Request from the bench
  input wire logic go,
  input wire tsq_pkg::tsq_bus_s word,
  // Bus
  output logic bus_valid,
  output tsq_pkg::tsq_bus_s bus
);
  import tsq_pkg::*;
  initial begin
    bus_valid = 1'b0;
    bus = '0;
  end
  always @(posedge clk) begin
    bus_valid <= go;
    bus <= go ? word : ~bus;
  end
endmodule // tsq_bus_model

// ==== tsq_pkg.sv ====
package tsq_pkg;

  // Test states and program geometry
  localparam int NUM_TESTS = 4;
  localparam int NUM_CLAUSES = 2;
  localparam int CTR_W = 20;
  localparam logic [1:0] TEST_RESET = 2'h0;

  // Counter sources
  localparam logic [1:0] SRC_EVENTS = 2'h0;
  localparam logic [1:0] SRC_US = 2'h1;
  localparam logic [1:0] SRC_MS = 2'h2;

  // Time counter actions
  localparam logic [1:0] ACT_RUN = 2'h0;
  localparam logic [1:0] ACT_STOP = 2'h1;
  localparam logic [1:0] ACT_RESET_RUN = 2'h2;

  // Interval lengths at the 250 MHz clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int MS_NS = 1000000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int PRESCALE_W = 18;

  // One sampled bus cycle of the system under test
  typedef struct packed {
    logic [7:0] data;
    logic [15:0] addr;
    logic [6:0] qual;
  } tsq_bus_s;

  // Pattern: value plus care masks; a zero mask bit is don't care
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_care;
    logic [15:0] addr;
    logic [15:0] addr_care;
    logic [6:0] qual;
    logic [6:0] qual_care;
  } tsq_pattern_s;

  // One clause: OR of selected conditions, then a bracketed action list
  typedef struct packed {
    logic use_wr1;
    logic use_wr2;
    logic use_counter_one_value;
    logic use_ctr2;
    logic is_else;
    logic act_trigger;
    logic act_goto;
    logic [1:0] goto_test;
    logic act_counter_one_value;
    logic [1:0] counter_one_value_act;
    logic act_ctr2;
    logic [1:0] ctr2_act;
  } tsq_clause_s;

  typedef struct packed {
    logic [1:0] source;
    logic [CTR_W-1:0] limit;
  } tsq_ctr_cfg_s;

  typedef enum logic [1:0] {
    TSQ_IDLE,
    TSQ_ARMED,
    TSQ_DONE
  } tsq_run_e;

endpackage

// ==== tsq_trigger_sequencer.sv ====
`timescale 1ns/1ns
// Contract
// - Address A then B next cycle triggers
// - Else branch: bump counter one, return
// - Two matchers evaluated together, either triggers
// - Bracketed conditions form one compound event
// - Separate trigger clauses equal OR-compound
// - Source code 0 events, 1 us, 2 ms
// - Events increment; time sources run/stop/reset
// - Run continues from held value
// - Stop holds present value
// - Reset-and-run clears then counts
// - Compare true when counter reaches limit
// - Delayed trigger after interval from match
// - Window trigger, elapsed time kept
// - Start monitors; trigger stops acquisition
// - Bracketed actions all execute same cycle; with a trigger the code drops goto and stops time counters
// - Empty test state ignores inputs
module tsq_trigger_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Operator control
  input wire logic start,
  // System-under-test bus sample
  input wire logic bus_valid,
  input wire tsq_pkg::tsq_bus_s bus,
  // Program
  input wire tsq_pkg::tsq_pattern_s wr1_pattern,
  input wire tsq_pkg::tsq_pattern_s wr2_pattern,
  input wire tsq_pkg::tsq_ctr_cfg_s counter_one_value_cfg,
  input wire tsq_pkg::tsq_ctr_cfg_s ctr2_cfg,
  input wire tsq_pkg::tsq_clause_s [15:0] program_clauses,
  // Status
  output logic acquiring,
  output logic trigger,
  output logic triggered,
  output logic [1:0] current_test,
  output logic [1:0] trigger_test,
  output logic [19:0] counter_one_value,
  output logic [19:0] counter_two_value,
  output logic main_trigger,
  output logic trigger_before_data,
  output logic sut_continue,
  output logic standard_clock_qual
);
  import tsq_pkg::*;

  function automatic logic pat_match(tsq_pattern_s p, tsq_bus_s b);
    pat_match = (((p.data ^ b.data) & p.data_care) == 8'h00) &&
                (((p.addr ^ b.addr) & p.addr_care) == 16'h0000) &&
                (((p.qual ^ b.qual) & p.qual_care) == 7'h00);
  endfunction

  // Applies one counter action; time counters only advance on ticks
  function automatic logic [CTR_W-1:0] ctr_step(
    tsq_ctr_cfg_s cfg, logic [CTR_W-1:0] val, logic hit, logic [1:0] act,
    logic tick);
    ctr_step = val;
    if (cfg.source == SRC_EVENTS) begin
      if (hit) begin
        ctr_step = val + 20'h00001;
      end
    end else if (hit && act == ACT_RESET_RUN) begin
      ctr_step = 20'h00000;
    end else if (tick) begin
      ctr_step = val + 20'h00001;
    end
  endfunction

  function automatic logic next_run(tsq_ctr_cfg_s cfg, logic run,
    logic hit, logic [1:0] act);
    next_run = run;
    if (cfg.source != SRC_EVENTS && hit) begin
      unique case (act)
        ACT_RUN: next_run = 1'b1;
        ACT_STOP: next_run = 1'b0;
        ACT_RESET_RUN: next_run = 1'b1;
        default: next_run = run;
      endcase
    end
  endfunction

  function automatic logic tick_of(tsq_ctr_cfg_s cfg, logic us_t,
    logic ms_t);
    tick_of = (cfg.source == SRC_US) ? us_t :
              (cfg.source == SRC_MS) ? ms_t : 1'b0;
  endfunction

  tsq_run_e run_r, run_nxt;
  logic [1:0] test_r, test_nxt;
  logic [1:0] trig_test_r, trig_test_nxt;
  logic trig_r, trig_nxt;
  logic [CTR_W-1:0] c1_r, c1_nxt, c2_r, c2_nxt;
  logic run1_r, run1_nxt, run2_r, run2_nxt;
  logic [PRESCALE_W-1:0] us_div_r, us_div_nxt, ms_div_r, ms_div_nxt;
  logic us_tick, ms_tick;

  // Free-running time bases; shared by both counters
  always_comb begin
    us_tick = (us_div_r == PRESCALE_W'(US_CYCLES - 1));
    ms_tick = (ms_div_r == PRESCALE_W'(MS_CYCLES - 1));
    us_div_nxt = us_tick ? '0 : us_div_r + 1'b1;
    ms_div_nxt = ms_tick ? '0 : ms_div_r + 1'b1;
  end

  always_comb begin
    logic wr1, wr2, cmp1, cmp2, cond, any_hit, qual, t1, t2;
    logic h1, h2;
    logic [1:0] a1, a2;
    cond = 1'b0;
    t1 = 1'b0;
    t2 = 1'b0;
    wr1 = pat_match(wr1_pattern, bus);
    wr2 = pat_match(wr2_pattern, bus);
    cmp1 = (c1_r >= counter_one_value_cfg.limit);
    cmp2 = (c2_r >= ctr2_cfg.limit);
    qual = bus_valid && run_r == TSQ_ARMED;
    any_hit = 1'b0;
    h1 = 1'b0;
    h2 = 1'b0;
    a1 = ACT_RUN;
    a2 = ACT_RUN;
    run_nxt = run_r;
    test_nxt = test_r;
    trig_nxt = 1'b0;
    trig_test_nxt = trig_test_r;
    // Later clauses override goto and counter codes; trigger ORs
    for (int i = 0; i < NUM_CLAUSES; i++) begin
      tsq_clause_s c;
      c = program_clauses[{test_r, 2'(i)}];
      cond = (c.use_wr1 && wr1) || (c.use_wr2 && wr2) ||
             (c.use_counter_one_value && cmp1) || (c.use_ctr2 && cmp2);
      if (c.is_else) begin
        cond = !any_hit;
      end
      if (qual && cond) begin
        any_hit = any_hit || !c.is_else;
        // All actions of the clause happen together
        if (c.act_trigger) begin
          trig_nxt = 1'b1;
        end
        if (c.act_goto) begin
          test_nxt = c.goto_test;
        end
        if (c.act_counter_one_value) begin
          h1 = 1'b1;
          a1 = c.counter_one_value_act;
        end
        if (c.act_ctr2) begin
          h2 = 1'b1;
          a2 = c.ctr2_act;
        end
      end
    end
    // Empty clauses never fire, so an empty state simply waits
    t1 = run1_r && tick_of(counter_one_value_cfg, us_tick, ms_tick);
    t2 = run2_r && tick_of(ctr2_cfg, us_tick, ms_tick);
    c1_nxt = ctr_step(counter_one_value_cfg, c1_r, h1, a1, t1);
    c2_nxt = ctr_step(ctr2_cfg, c2_r, h2, a2, t2);
    run1_nxt = next_run(counter_one_value_cfg, run1_r, h1, a1);
    run2_nxt = next_run(ctr2_cfg, run2_r, h2, a2);
    if (trig_nxt) begin
      run_nxt = TSQ_DONE;
      trig_test_nxt = test_r;
      test_nxt = test_r;
      // Freeze time counters so the elapsed window stays readable
      run1_nxt = 1'b0;
      run2_nxt = 1'b0;
    end
    if (start) begin
      run_nxt = TSQ_ARMED;
      test_nxt = TEST_RESET;
      c1_nxt = '0;
      c2_nxt = '0;
      run1_nxt = 1'b0;
      run2_nxt = 1'b0;
      trig_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r <= TSQ_IDLE;
      test_r <= TEST_RESET;
      trig_test_r <= TEST_RESET;
      trig_r <= 1'b0;
      c1_r <= '0;
      c2_r <= '0;
      run1_r <= 1'b0;
      run2_r <= 1'b0;
      us_div_r <= '0;
      ms_div_r <= '0;
    end else begin
      run_r <= run_nxt;
      test_r <= test_nxt;
      trig_test_r <= trig_test_nxt;
      trig_r <= trig_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      run1_r <= run1_nxt;
      run2_r <= run2_nxt;
      us_div_r <= us_div_nxt;
      ms_div_r <= ms_div_nxt;
    end
  end

  assign acquiring = (run_r == TSQ_ARMED);
  assign trigger = trig_r;
  assign triggered = (run_r == TSQ_DONE);
  assign current_test = test_r;
  assign trigger_test = trig_test_r;
  assign counter_one_value = c1_r;
  assign counter_two_value = c2_r;
  // Only the default trigger flavour is built
  assign main_trigger = 1'b1;
  assign trigger_before_data = 1'b1;
  assign sut_continue = 1'b1;
  assign standard_clock_qual = 1'b1;

endmodule // tsq_trigger_sequencer

// ==== tsq_trigger_sequencer_bench.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  error_cnt++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tsq_trigger_sequencer_bench;
  import tsq_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic go = 1'b0;
  logic bus_valid;
  tsq_bus_s word = '0;
  tsq_bus_s bus;
  tsq_pattern_s wr1 = '0;
  tsq_pattern_s wr2 = '0;
  tsq_ctr_cfg_s counter_one_value_cfg = '0;
  tsq_ctr_cfg_s ctr2_cfg = '0;
  tsq_clause_s [15:0] prog = '0;
  tsq_pattern_s wr1_b;
  tsq_clause_s [15:0] prog_b;
  logic acquiring;
  logic trigger;
  logic [1:0] current_test;
  logic [1:0] trigger_test;
  logic triggered;
  logic [19:0] counter_one_value;
  logic [19:0] counter_two_value;
  logic [46:0] got;
  logic [46:0] exp_q[$];
  logic [15:0] seq1 [9] = '{16'h1234, 16'h783D, 16'h1234, 16'h783D,
    16'h783D, 16'h9107, 16'h783D, 16'h9107, 16'h783D};
  localparam int DLY_US = 12;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 32'h154B068A;
  int cyc = 0;
  int t;
  int c1;
  int c2;
  int mode;
  logic [1:0] tt = 2'h0;
  bit tr;
  bit run;
  tsq_bus_model tsq_bus_model_i (.clk(clk), .go(go), .word(word),
    .bus_valid(bus_valid), .bus(bus));
  tsq_trigger_sequencer tsq_trigger_sequencer_i (.clk(clk),
    .arst_n(arst_n), .start(start), .bus_valid(bus_valid), .bus(bus),
    .wr1_pattern(wr1), .wr2_pattern(wr2), .counter_one_value_cfg(counter_one_value_cfg),
    .ctr2_cfg(ctr2_cfg), .program_clauses(prog),
    .acquiring(acquiring), .trigger(trigger), .triggered(triggered),
    .current_test(current_test), .trigger_test(trigger_test),
    .counter_one_value(counter_one_value),
    .counter_two_value(counter_two_value), .main_trigger(),
    .trigger_before_data(), .sut_continue(), .standard_clock_qual());
  assign got = {trigger_test, current_test, triggered, trigger, acquiring,
    counter_one_value, counter_two_value};
  // Edges since reset release; the prescaler phase follows from it
  always @(posedge clk) begin
    if (arst_n) begin
      cyc <= cyc + 1;
    end
  end
  task automatic end_sim();
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Idle first so no word is in flight when start lands
  task automatic arm(input int m);
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    mode = m;
    t = 0;
    c1 = 0;
    c2 = 0;
    tr = 0;
    run = 0;
  endtask
  // Words go back to back; the model steps once per word, which the
  // design evaluates two edges after this call's edge
  task automatic step(input logic [15:0] a, input logic [7:0] d);
    bit was;
    bit tk;
    int n;
    @(posedge clk);
    n = cyc + 3;
    was = tr;
    go <= 1'b1;
    word <= {d, a, 7'($random(seed))};
    if (!tr) begin
      if (mode == 1) begin
        tr = (a == 16'hF836) || (d == 8'h41);
      end else if (mode == 2) begin
        tk = run && (n % US_CYCLES == 0);
        if (d == 8'h1D) c2++;
        if (t == 1 && c1 >= DLY_US) tr = 1;
        c1 = (t == 1 && d == 8'h1D) ? 0 : tk ? c1 + 1 : c1;
        if (d == 8'h1D) begin
          run = 1;
          t = 1;
        end
        if (tr) run = 0;
      end else if (t == 0) begin
        t = (a == 16'h783D);
      end else if (a == 16'h9107) begin
        tr = 1;
      end else begin
        c1++;
        t = 0;
      end
    end
    if (tr && !was) tt = t[1:0];
    exp_q.push_back({tt, t[1:0], tr, tr && !was, !tr, c1[19:0], c2[19:0]});
  endtask
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (bus_valid === 1'b1) begin
      #1;
      `CHK(got, exp_q.pop_front())
    end
  end
  initial begin
    wr1.addr = 16'h783D;
    wr1.addr_care = 16'hFFFF;
    wr2.addr = 16'h9107;
    wr2.addr_care = 16'hFFFF;
    prog[0].use_wr1 = 1'b1;
    prog[0].act_goto = 1'b1;
    prog[0].goto_test = 2'h1;
    prog[4].use_wr2 = 1'b1;
    prog[4].act_trigger = 1'b1;
    prog[5].is_else = 1'b1;
    prog[5].act_goto = 1'b1;
    prog[5].act_counter_one_value = 1'b1;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    arm(0);
    foreach (seq1[i]) step(seq1[i], 8'($random(seed)));
    wr1_b = '0;
    wr1_b.data = 8'h41;
    wr1_b.data_care = 8'hFF;
    prog_b = '0;
    prog_b[0].use_wr1 = 1'b1;
    prog_b[0].use_wr2 = 1'b1;
    prog_b[0].act_trigger = 1'b1;
    arm(1);
    wr1 <= wr1_b;
    wr2.addr <= 16'hF836;
    prog <= prog_b;
    step(16'h1234, 8'h40);
    step(16'hF835, 8'($random(seed)));
    step(16'hF836, 8'($random(seed)));
    arm(1);
    step(16'hF836, 8'h42);
    step(16'h0000, 8'h41);
    arm(1);
    step(16'h0000, 8'h41);
    step(16'hF836, 8'h41);
    // Delayed trigger on a us counter; a second match restarts it
    wr1_b.data = 8'h1D;
    prog_b = '0;
    prog_b[0].use_wr1 = 1'b1;
    prog_b[0].act_goto = 1'b1;
    prog_b[0].goto_test = 2'h1;
    prog_b[0].act_counter_one_value = 1'b1;
    prog_b[0].counter_one_value_act = ACT_RUN;
    prog_b[0].act_ctr2 = 1'b1;
    prog_b[4].use_counter_one_value = 1'b1;
    prog_b[4].act_trigger = 1'b1;
    prog_b[5].use_wr1 = 1'b1;
    prog_b[5].act_counter_one_value = 1'b1;
    prog_b[5].counter_one_value_act = ACT_RESET_RUN;
    prog_b[5].act_ctr2 = 1'b1;
    arm(2);
    wr1 <= wr1_b;
    prog <= prog_b;
    counter_one_value_cfg <= '{SRC_US, 20'(DLY_US)};
    step(16'h1234, 8'h00);
    step(16'($random(seed)), 8'h1D);
    for (int i = 0; i < 3500; i++) begin
      step(16'($random(seed)), (i == 100) ? 8'h1D : 8'h00);
    end
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    end_sim();
  end
  initial begin
    #30000;
    error_cnt++;
    end_sim();
  end
endmodule // tsq_trigger_sequencer_bench

// ==== tsq_trigger_sequencer_properties.sv ====
`timescale 1ns/1ns
module tsq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs
  input wire logic start,
  input wire logic bus_valid,
  // Status
  input wire logic acquiring,
  input wire logic trigger,
  input wire logic triggered,
  input wire logic [1:0] current_test,
  input wire logic [19:0] counter_one_value,
  input wire logic main_trigger,
  input wire logic trigger_before_data,
  input wire logic sut_continue,
  input wire logic standard_clock_qual
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger wider than one cycle");
  chk_trig_stops: assert property (trigger |-> triggered && !acquiring)
    else $error("trigger left acquisition running");
  chk_acq_drop: assert property ($fell(acquiring) |-> trigger)
    else $error("acquisition ended without trigger");
  chk_start_arms: assert property (start |=> acquiring && !triggered
    && current_test == 2'h0 && counter_one_value == 20'h0)
    else $error("start did not arm");
  chk_no_take: assert property (!(acquiring && bus_valid) && !start
    |=> $stable(current_test) && !trigger)
    else $error("state moved without a taken cycle");
  chk_trig_cause: assert property ($rose(triggered)
    |-> $past(acquiring) && $past(bus_valid))
    else $error("trigger without a bus cycle");
  chk_done_hold: assert property (triggered && !start
    |=> triggered && $stable(counter_one_value))
    else $error("status changed after trigger");
  chk_trig_defaults: assert property (main_trigger && sut_continue
    && trigger_before_data && standard_clock_qual)
    else $error("trigger defaults wrong");
endmodule // tsq_checker
bind tsq_trigger_sequencer tsq_checker tsq_checker_i (.clk(clk),
  .arst_n(arst_n), .start(start), .bus_valid(bus_valid),
  .acquiring(acquiring), .trigger(trigger), .triggered(triggered),
  .current_test(current_test), .counter_one_value(counter_one_value),
  .main_trigger(main_trigger), .trigger_before_data(trigger_before_data),
  .sut_continue(sut_continue), .standard_clock_qual(standard_clock_qual));
